// >>> core/pmic_flags_cfg.svh
// How it works
// - status bit 7 shows freshness seal: 0 intact, 1 broken
// - status bit 6 shows nvm changed from factory defaults
// - status bit 5 is adapter-detect pin inverted
// - status bit 4 is push-button pin inverted
// - status bits 3:2 give sequencer state 0..3
// - status bits 1:0 give coin-cell charge level 0..3
// - status bits have no reset, all eight follow live state
// - shutdown enable plus low power-fail output forces all rails off
// - with shutdown enable clear, power-fail output is ignored
// - writing one to trigger bit starts measurement, bit self-clears
// - control resets to zero, bits 7:2 read zero
// - on wake each flag set if its rail stayed on in suspend
// - flag reads zero after power-up from off or rail off
// - flag register read-only, resets to zero
`ifndef PMIC_FLAGS_CFG_SVH
`define PMIC_FLAGS_CFG_SVH
`define ADDR_DEVICE_STATUS 8'h05
`define ADDR_DEVICE_CONTROL 8'h06
`define ADDR_SUSPEND_RAIL_FLAGS 8'h07
`define BIT_SEAL 7
`define BIT_NVM 6
`define BIT_ADAPTER 5
`define BIT_BUTTON 4
`define BIT_PF_EN 1
`define BIT_CC_TRIG 0
`define BIT_STATE_HI 3
`define BIT_STATE_LO 2
`define BIT_CHARGE_HI 1
`define BIT_CHARGE_LO 0
`define RST_CONTROL 8'h00
`define RST_PF_EN 1'h0
`define RST_CC_TRIG 1'h0
`define RST_SHUTDOWN 1'h0
`define RST_FLAGS 8'h00
`define RST_READ 8'h00
`endif

// >>> core/pmic_flags_pkg.sv
package pmic_flags_pkg;
	typedef enum logic [1:0] {
		seq_transition = 2'b00,
		seq_wait_power_enable = 2'b01,
		seq_active = 2'b10,
		seq_suspend = 2'b11
	} seq_state_e;
endpackage : pmic_flags_pkg

// >>> core/suspend_flag_capture.sv
`timescale 1ns/1ns
`include "pmic_flags_cfg.svh"
module suspend_flag_capture (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_resetn,
	// sequencer view
	input wire pmic_flags_pkg::seq_state_e i_state,
	input wire logic i_from_off,
	input wire logic [7:0] i_rail_on,
	// flags
	output logic [7:0] o_flags
);
	pmic_flags_pkg::seq_state_e prev_state;

	// remember last state to find the suspend exit
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			prev_state <= pmic_flags_pkg::seq_transition;
		end else begin
			prev_state <= i_state;
		end
	end

	// capture rail enables once per wake, clear on power-up from off, hold otherwise
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			o_flags <= `RST_FLAGS;
		end else if (i_from_off) begin
			o_flags <= `RST_FLAGS;
		end else if (prev_state == pmic_flags_pkg::seq_suspend &&
				i_state != pmic_flags_pkg::seq_suspend) begin
			// rails sampled in the first cycle after leaving suspend, not the previous one
			o_flags <= i_rail_on;
		end
	end
endmodule : suspend_flag_capture

// >>> core/pmic_status_control_flags.sv
`timescale 1ns/1ns
`include "pmic_flags_cfg.svh"
module pmic_status_control_flags (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_resetn,
	// register port
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// device state inputs
	input wire logic i_freshness_seal,
	input wire logic i_nvm_modified,
	input wire logic i_adapter_detect_input,
	input wire logic i_push_button_input,
	input wire pmic_flags_pkg::seq_state_e i_seq_state,
	input wire logic [1:0] i_coin_cell_charge_level,
	input wire logic i_powerfail_output_n,
	input wire logic i_from_off,
	// rail enables, bit order as flag register
	input wire logic [7:0] i_rail_on,
	// outputs to sequencer and coin-cell adc
	output logic o_powerfail_shutdown,
	output logic o_coin_cell_measure_start,
	output logic o_powerfail_shutdown_enable
);
	// flag register contents from the capture block
	logic [7:0] flags;

	// live status word, rebuilt every cycle
	logic [7:0] status_word;

	// control word as software reads it back
	logic [7:0] control_word;

	// decoded write strobes
	logic ctl_wr;
	logic trig_wr;

	// decoded read selects
	logic sel_status;
	logic sel_control;
	logic sel_flags;

	// next values, one per stored item
	logic next_pf_en;
	logic next_measure_start;
	logic next_shutdown;
	logic [7:0] next_rdata;

	// address match, shared by the write and read decoders
	function automatic logic addr_hit(
		input logic [7:0] addr,
		input logic [7:0] target
	);
		return addr == target;
	endfunction : addr_hit

	// status packing; both pins are active low, so their bits invert
	function automatic logic [7:0] pack_status(
		input logic seal,
		input logic nvm,
		input logic adapter_pin,
		input logic button_pin,
		input logic [1:0] state,
		input logic [1:0] charge
	);
		logic [7:0] word;
		word = `RST_READ;
		word[`BIT_SEAL] = seal;
		word[`BIT_NVM] = nvm;
		word[`BIT_ADAPTER] = ~adapter_pin;
		word[`BIT_BUTTON] = ~button_pin;
		word[`BIT_STATE_HI:`BIT_STATE_LO] = state;
		// charge is only meaningful after a measurement
		word[`BIT_CHARGE_HI:`BIT_CHARGE_LO] = charge;
		return word;
	endfunction : pack_status

	// control packing; reserved bits and the trigger read zero
	function automatic logic [7:0] pack_control(
		input logic pf_en
	);
		logic [7:0] word;
		word = `RST_CONTROL;
		word[`BIT_PF_EN] = pf_en;
		return word;
	endfunction : pack_control

	// rail flags captured on each wake from suspend
	suspend_flag_capture u_flags (
		.i_mclk(i_mclk),
		.i_resetn(i_resetn),
		.i_state(i_seq_state),
		.i_from_off(i_from_off),
		.i_rail_on(i_rail_on),
		.o_flags(flags)
	);

	// write decode; writes to read-only addresses fall through
	always_comb begin
		ctl_wr = i_reg_wr && addr_hit(i_reg_addr, `ADDR_DEVICE_CONTROL);
		trig_wr = ctl_wr && i_reg_wdata[`BIT_CC_TRIG];
	end

	// read decode, one select per mapped register
	always_comb begin
		sel_status = addr_hit(i_reg_addr, `ADDR_DEVICE_STATUS);
		sel_control = addr_hit(i_reg_addr, `ADDR_DEVICE_CONTROL);
		sel_flags = addr_hit(i_reg_addr, `ADDR_SUSPEND_RAIL_FLAGS);
	end

	// live status word assembly
	always_comb begin
		status_word = pack_status(
			i_freshness_seal,
			i_nvm_modified,
			i_adapter_detect_input,
			i_push_button_input,
			i_seq_state,
			i_coin_cell_charge_level
		);
	end

	// control read-back view
	always_comb begin
		control_word = pack_control(o_powerfail_shutdown_enable);
	end

	// shutdown enable holds until software rewrites it
	always_comb begin
		next_pf_en = o_powerfail_shutdown_enable;
		if (ctl_wr) begin
			next_pf_en = i_reg_wdata[`BIT_PF_EN];
		end
	end

	// trigger never stores, so it looks self-clearing to software
	always_comb begin
		next_measure_start = trig_wr;
	end

	// comparator is ignored unless shutdown is enabled
	always_comb begin
		next_shutdown = o_powerfail_shutdown_enable &&
			!i_powerfail_output_n;
	end

	// read mux; data holds between reads so the host may sample late
	always_comb begin
		next_rdata = o_reg_rdata;
		if (i_reg_rd) begin
			if (sel_status) begin
				next_rdata = status_word;
			end else if (sel_control) begin
				next_rdata = control_word;
			end else if (sel_flags) begin
				next_rdata = flags;
			end else begin
				next_rdata = `RST_READ;
			end
		end
	end

	// shutdown enable bit; other bits of control stay zero
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			o_powerfail_shutdown_enable <= `RST_PF_EN;
		end else begin
			o_powerfail_shutdown_enable <= next_pf_en;
		end
	end

	// one-cycle measurement start pulse to the coin-cell adc
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			o_coin_cell_measure_start <= `RST_CC_TRIG;
		end else begin
			o_coin_cell_measure_start <= next_measure_start;
		end
	end

	// registered shutdown request, one cycle behind the comparator;
	// the extra cycle is traded for a glitch-free output
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			o_powerfail_shutdown <= `RST_SHUTDOWN;
		end else begin
			o_powerfail_shutdown <= next_shutdown;
		end
	end

	// read data registered; unmapped reads return zero
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			o_reg_rdata <= `RST_READ;
		end else begin
			o_reg_rdata <= next_rdata;
		end
	end
endmodule : pmic_status_control_flags

// >>> dv/pmic_flags_asserts.sv
`timescale 1ns/1ns
module pmic_flags_asserts (
	// watched ports
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata,
	input wire logic i_freshness_seal,
	input wire logic i_powerfail_output_n,
	input wire logic o_powerfail_shutdown,
	input wire logic o_coin_cell_measure_start,
	input wire logic o_powerfail_shutdown_enable
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	// short aliases keep each property on a line or two
	wire en = o_powerfail_shutdown_enable;
	wire w6 = i_reg_wr && i_reg_addr == 8'h06;
	wire t6 = w6 && i_reg_wdata[0];
	wire r6 = i_reg_rd && i_reg_addr == 8'h06 && !i_reg_wr;
	a_seal_bit: assert property (i_reg_rd && i_reg_addr == 8'h05 |=>
		o_reg_rdata[7] == $past(i_freshness_seal)) else $error("seal");
	a_ctrl_read: assert property (r6 |=>
		o_reg_rdata == {6'h00, $past(en), 1'h0}) else $error("ctrl");
	a_trig_pulse: assert property (t6 |=> o_coin_cell_measure_start)
		else $error("trig");
	a_trig_only: assert property (!t6 |=> !o_coin_cell_measure_start)
		else $error("extra");
	a_en_write: assert property (w6 |=> en == $past(i_reg_wdata[1]))
		else $error("en");
	a_en_hold: assert property (!w6 |=> $stable(en)) else $error("hold");
	a_pf_trip: assert property (en && !i_powerfail_output_n |=>
		o_powerfail_shutdown) else $error("trip");
	a_pf_mask: assert property (!en |=> !o_powerfail_shutdown)
		else $error("mask");
	c_trig: cover property (o_coin_cell_measure_start);
	c_trip: cover property (o_powerfail_shutdown);
	c_ctrl: cover property (r6);
endmodule : pmic_flags_asserts
bind pmic_status_control_flags pmic_flags_asserts chk_u (.i_mclk, .i_resetn,
	.i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
	.i_freshness_seal, .i_powerfail_output_n, .o_powerfail_shutdown,
	.o_coin_cell_measure_start, .o_powerfail_shutdown_enable);

// >>> dv/host_model.sv
`timescale 1ns/1ns
module host_model (
	// register requests
	input wire logic i_mclk,
	output logic o_wr = 1'h0,
	output logic o_rd = 1'h0,
	output logic [7:0] o_addr = 8'h00,
	output logic [7:0] o_wdata = 8'h00
);
	// one idle edge after each strobe so it never re-asserts in one step
	task automatic acc(input logic w, input logic [7:0] a, d);
		{o_wr, o_rd, o_addr, o_wdata} <= {w, !w, a, d};
		@(posedge i_mclk);
		{o_wr, o_rd} <= 2'h0;
		@(posedge i_mclk);
	endtask : acc
endmodule : host_model

// >>> dv/pmic_status_control_flags_tb.sv
`timescale 1ns/1ns
module pmic_status_control_flags_tb;
	logic i_mclk = 1'h0, i_resetn = 1'h0, pfn = 1'h1, off = 1'h0;
	logic [7:0] v = 8'h00, rails = 8'h00, r, rdata, addr, wdata;
	logic wr, rd, shut, go, en;
	integer seed = 32'hdfca38e1, checks = 0, num_errors = 0;
	// free-running clock
	always #2 i_mclk = ~i_mclk;
	host_model h (.i_mclk, .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
	pmic_status_control_flags dut_u (.i_mclk, .i_resetn, .i_reg_wr(wr),
		.i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.o_reg_rdata(rdata), .i_freshness_seal(v[7]), .i_nvm_modified(v[6]),
		.i_adapter_detect_input(v[5]), .i_push_button_input(v[4]),
		.i_seq_state(pmic_flags_pkg::seq_state_e'(v[3:2])),
		.i_coin_cell_charge_level(v[1:0]), .i_powerfail_output_n(pfn),
		.i_from_off(off), .i_rail_on(rails), .o_powerfail_shutdown(shut),
		.o_coin_cell_measure_start(go), .o_powerfail_shutdown_enable(en));
	// both pins are active low, so their status bits read inverted
	function automatic logic [7:0] st_exp(input logic [7:0] x);
		return x ^ 8'h30;
	endfunction : st_exp
	task automatic chk(input string n, input logic [7:0] e, g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic rdc(input logic [7:0] a, e);
		h.acc(1'h0, a, 8'h00);
		chk("rdata", e, rdata);
	endtask : rdc
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict
	// all waits are fixed counts, so no hang is possible
	initial begin
		repeat (12) @(posedge i_mclk);
		i_resetn <= 1'h1;
		repeat (2) @(posedge i_mclk);
		rdc(8'h06, 8'h00);
		rdc(8'h07, 8'h00);
		rdc(8'h05, st_exp(v));
		rdc(8'h2a, 8'h00);
		h.acc(1'h1, 8'h06, 8'h01);
		chk("go", 8'h01, {7'h00, go});
		for (int i = 0; i < 8; i++) begin
			r = {4'($random(seed)), 2'(i), 2'(i)};
			v <= r;
			rdc(8'h05, st_exp(r));
		end
		h.acc(1'h1, 8'h06, 8'hff);
		chk("go", 8'h01, {7'h00, go});
		chk("en", 8'h01, {7'h00, en});
		rdc(8'h06, 8'h02);
		pfn <= 1'h0;
		repeat (2) @(posedge i_mclk);
		chk("shut", 8'h01, {7'h00, shut});
		h.acc(1'h1, 8'h06, 8'h00);
		@(posedge i_mclk);
		chk("shut", 8'h00, {7'h00, shut});
		// rails change after the wake edge to prove the capture holds
		r = $random(seed);
		{rails, v} <= {r, 8'h0c};
		repeat (2) @(posedge i_mclk);
		v <= 8'h08;
		@(posedge i_mclk);
		rails <= ~r;
		h.acc(1'h1, 8'h07, 8'hff);
		rdc(8'h07, r);
		off <= 1'h1;
		@(posedge i_mclk);
		off <= 1'h0;
		rdc(8'h07, 8'h00);
		// mid-run reset while shutdown is armed and tripped
		h.acc(1'h1, 8'h06, 8'h02);
		@(posedge i_mclk);
		chk("shut", 8'h01, {7'h00, shut});
		i_resetn <= 1'h0;
		repeat (12) @(posedge i_mclk);
		i_resetn <= 1'h1;
		@(posedge i_mclk);
		chk("en", 8'h00, {7'h00, en});
		@(posedge i_mclk);
		chk("shut", 8'h00, {7'h00, shut});
		rdc(8'h06, 8'h00);
		rdc(8'h07, 8'h00);
		give_verdict();
	end
endmodule : pmic_status_control_flags_tb
